// ### efs_pkg.sv
/*
  efs_pkg: register indices, field positions, reset values, unlock keys,
  memory geometry and state types of the nonvolatile access controller.
  Assumes one core clock domain and a byte-wide special register port.
*/
`default_nettype none

package efs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register indices on the special register port
  localparam logic [2:0] IDX_DATA_LOW = 3'h0;
  localparam logic [2:0] IDX_ADDR_LOW = 3'h1;
  localparam logic [2:0] IDX_DATA_HIGH = 3'h2;
  localparam logic [2:0] IDX_ADDR_HIGH = 3'h3;
  localparam logic [2:0] IDX_CONTROL = 3'h4;
  localparam logic [2:0] IDX_UNLOCK = 3'h5;
  localparam logic [2:0] IDX_FLAGS2 = 3'h6;

  ////////////////////////////////////////////////////////////////////////
  // control and flag register fields
  localparam int CTL_FETCH = 0;
  localparam int CTL_COMMIT = 1;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_ABORT = 3;
  localparam int CTL_SPACE = 7;
  localparam int FLG_DONE = 4;

  ////////////////////////////////////////////////////////////////////////
  // widths and values
  localparam int DATA_HIGH_W = 6;
  localparam int ADDR_HIGH_W = 5;
  localparam int WORD_W = 14;
  localparam int PADDR_W = 13;
  localparam int EE_DEPTH = 256;
  localparam int PROG_AW_DEF = 12;
  localparam int WRITE_CYCLES_DEF = 400;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [13:0] WORD_ZERO = 14'h0000;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  ////////////////////////////////////////////////////////////////////////
  // self-write protection codes and the protected word boundaries
  localparam logic [1:0] PROT_NONE = 2'h3;
  localparam logic [1:0] PROT_LOW = 2'h2;
  localparam logic [1:0] PROT_HALF = 2'h1;
  localparam logic [12:0] PROT_LOW_LIMIT = 13'h0100;

  ////////////////////////////////////////////////////////////////////////
  // state types
  typedef enum logic [1:0] {
    EFS_LOCKED,
    EFS_HALF,
    EFS_ARMED
  } efs_unlock_t;

  typedef enum logic [1:0] {
    EFS_OP_IDLE,
    EFS_OP_PREAD,
    EFS_OP_WRITE
  } efs_op_t;

endpackage : efs_pkg

`default_nettype wire

// ### efs_core.sv
/*
  efs_core: indirect access to a 256-byte data EEPROM and a flash program
  array through byte registers, with unlock sequence, timed writes,
  self-write protection and a code-protected programmer read port.
  Assumes all inputs, configuration included, come from sys_clk logic.
*/
//
// Operation
// (R1) data bytes 0..ff addressed by low address only, byte access
// (R2) program access joins data pair into 14-bit word, address pair
// (R3) program address width is a build parameter, one word per read
// (R4) address pair reaches 256 data bytes or 8K program words
// (R5) software loads high and low address, or only low for data
// (R6) a data byte write erases the location then stores the byte
// (R7) write duration comes from an internal cycle counter
// (R8) self-writes to protected program segments are refused
// (R9) code protection denies programmer reads, CPU access unaffected
// (R10) space select at bit 7 picks data or program, zero after reset
// (R11) fetch and commit bits set by software only, cleared by hardware
// (R12) commit permit gates write cycles, zero at power-up
// (R13) abort flag set when reset cuts a write, zero on completion
// (R14) done flag set when a write finishes, cleared only by software
// (R15) unlock port has no storage and reads zero
// (R16) high data holds word bits 13..8 in 5..0, upper bits read zero
// (R17) high address uses bits 4..0, bits 7..5 read zero
// (R18) write starts only after 55h, aah, then commit bit set
// (R19) commit bit cannot be set unless permit is already one
// (R20) data fetch shows the byte in low data on the next cycle
// (R21) program fetch stalls the second cycle, then shows the word
// (R22) any off-sequence unlock access or other write relocks
// (R23) arrays are behavioural, write time a parameter in cycles
`default_nettype none

module efs_core #(
  parameter int PROG_AW = efs_pkg::PROG_AW_DEF,
  parameter int WRITE_CYCLES = efs_pkg::WRITE_CYCLES_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic power_on,
  // special register port
  input wire logic [2:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // configuration
  input wire logic [1:0] self_program_protect,
  input wire logic code_protect,
  // core status
  output logic cpu_stall,
  output logic nvm_done_flag,
  // external programmer read port
  input wire logic pgm_rd,
  input wire logic pgm_space,
  input wire logic [12:0] pgm_addr,
  output logic [13:0] pgm_rdata,
  output logic pgm_valid,
  output logic pgm_denied
);

  localparam int PROG_WORDS = 1 << PROG_AW;
  localparam logic [15:0] WR_LAST = 16'(WRITE_CYCLES - 1);
  localparam logic [15:0] ERASE_AT = 16'(WRITE_CYCLES / 2);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [PROG_AW-1:0] prog_index(
    input logic [12:0] a
  );
    prog_index = a[PROG_AW-1:0]; // R3
  endfunction : prog_index

  function automatic logic is_protected(
    input logic [1:0] code,
    input logic [12:0] a
  );
    logic [12:0] half;
    half = 13'(PROG_WORDS / 2);
    case (code)
      efs_pkg::PROT_NONE: is_protected = 1'b0;
      efs_pkg::PROT_LOW: is_protected = a < efs_pkg::PROT_LOW_LIMIT;
      efs_pkg::PROT_HALF: is_protected = a < half;
      default: is_protected = 1'b1;
    endcase
  endfunction : is_protected

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] ee_mem [0:efs_pkg::EE_DEPTH-1];
  logic [13:0] pm_mem [0:PROG_WORDS-1];
  logic [7:0] data_low_r;
  logic [7:0] addr_low_r;
  logic [5:0] data_high_r;
  logic [4:0] addr_high_r;
  logic space_r;
  logic abort_r;
  logic permit_r;
  logic commit_r;
  logic fetch_r;
  logic done_r;
  efs_pkg::efs_unlock_t unlock_r;
  efs_pkg::efs_op_t op_r;
  logic [15:0] cnt_r;
  logic stall_r;
  logic [12:0] wr_addr_r;
  logic [13:0] wr_data_r;
  logic wr_space_r;
  logic [7:0] sfr_rdata_r;
  logic [13:0] pgm_rdata_r;
  logic pgm_valid_r;
  logic pgm_denied_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // decode

  wire wr_dlo = sfr_wr && (sfr_sel == efs_pkg::IDX_DATA_LOW);
  wire wr_alo = sfr_wr && (sfr_sel == efs_pkg::IDX_ADDR_LOW);
  wire wr_dhi = sfr_wr && (sfr_sel == efs_pkg::IDX_DATA_HIGH);
  wire wr_ahi = sfr_wr && (sfr_sel == efs_pkg::IDX_ADDR_HIGH);
  wire wr_ctl = sfr_wr && (sfr_sel == efs_pkg::IDX_CONTROL);
  wire wr_key = sfr_wr && (sfr_sel == efs_pkg::IDX_UNLOCK);
  wire wr_flg = sfr_wr && (sfr_sel == efs_pkg::IDX_FLAGS2);
  wire rd_key = sfr_rd && (sfr_sel == efs_pkg::IDX_UNLOCK);
  wire op_idle = (op_r == efs_pkg::EFS_OP_IDLE);
  wire busy = (op_r == efs_pkg::EFS_OP_WRITE);
  wire space_nxt = wr_ctl ? sfr_wdata[efs_pkg::CTL_SPACE] : space_r;
  wire [12:0] prog_addr = {addr_high_r, addr_low_r}; // R2 R4 R5
  wire [7:0] ee_rd = ee_mem[addr_low_r]; // R1
  wire [13:0] pm_rd = pm_mem[prog_index(prog_addr)];
  wire armed = (unlock_r == efs_pkg::EFS_ARMED);
  wire prot_hit = is_protected(self_program_protect, prog_addr);
  wire commit_req = wr_ctl && sfr_wdata[efs_pkg::CTL_COMMIT] && op_idle;
  wire commit_go = commit_req && armed && permit_r // R18 R19 R12
    && !(space_nxt && prot_hit); // R8
  localparam logic [15:0] CNT_ONE_W = efs_pkg::CNT_ONE;
  wire fetch_go = wr_ctl && sfr_wdata[efs_pkg::CTL_FETCH] && op_idle
    && !commit_go;
  wire ee_load = fetch_go && !space_nxt; // R20
  wire pm_load = (op_r == efs_pkg::EFS_OP_PREAD) && (cnt_r == CNT_ONE_W);
  wire wr_erase = busy && (cnt_r == ERASE_AT); // R6
  wire wr_done = busy && (cnt_r == WR_LAST); // R7

  ////////////////////////////////////////////////////////////////////////
  // unlock tracker

  efs_pkg::efs_unlock_t unlock_nxt;
  assign unlock_nxt =
    (wr_key && sfr_wdata == efs_pkg::UNLOCK_KEY1) ? efs_pkg::EFS_HALF :
    (wr_key && sfr_wdata == efs_pkg::UNLOCK_KEY2 &&
     unlock_r == efs_pkg::EFS_HALF) ? efs_pkg::EFS_ARMED : // R18
    (sfr_wr || rd_key) ? efs_pkg::EFS_LOCKED : // R22
    unlock_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      unlock_r <= efs_pkg::EFS_LOCKED;
    else
      unlock_r <= unlock_nxt;
  end

  chk_unlock_order: assert property ($rose(commit_r) |->
    $past(unlock_r) == efs_pkg::EFS_ARMED) // R18
    else $error("write started without the unlock sequence");

  chk_relock_other: assert property (
    (sfr_wr && !wr_key) |=> unlock_r == efs_pkg::EFS_LOCKED) // R22
    else $error("unlock tracker not idle after another write");

  ////////////////////////////////////////////////////////////////////////
  // data and address registers

  wire [7:0] data_low_nxt = ee_load ? ee_rd :
    pm_load ? pm_rd[7:0] : wr_dlo ? sfr_wdata : data_low_r; // R20 R21
  wire [5:0] data_high_nxt = pm_load ? pm_rd[13:8] :
    wr_dhi ? sfr_wdata[5:0] : data_high_r; // R16
  wire [7:0] addr_low_nxt = wr_alo ? sfr_wdata : addr_low_r;
  wire [4:0] addr_high_nxt = wr_ahi ? sfr_wdata[4:0] : addr_high_r; // R17

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      data_low_r <= efs_pkg::BYTE_ZERO;
      addr_low_r <= efs_pkg::BYTE_ZERO;
      data_high_r <= '0;
      addr_high_r <= '0;
    end
    else
    begin
      data_low_r <= data_low_nxt;
      addr_low_r <= addr_low_nxt;
      data_high_r <= data_high_nxt;
      addr_high_r <= addr_high_nxt;
    end
  end

  chk_fetch_data_next: assert property (ee_load |=>
    data_low_r == $past(ee_rd)) // R20
    else $error("data byte not presented on the next cycle");

  ////////////////////////////////////////////////////////////////////////
  // control bits and flags

  // software may only set fetch and commit; zeros written are dropped
  wire commit_nxt = commit_go ? 1'b1 : wr_done ? 1'b0 : commit_r; // R11
  wire fetch_nxt = (fetch_go && space_nxt) ? 1'b1 :
    pm_load ? 1'b0 : fetch_r; // R11
  wire permit_nxt = wr_ctl ? sfr_wdata[efs_pkg::CTL_PERMIT] : permit_r;
  wire abort_nxt = wr_done ? 1'b0 : // R13
    wr_ctl ? sfr_wdata[efs_pkg::CTL_ABORT] : abort_r;
  // completion wins over a clear written in the same cycle
  wire done_nxt = wr_done ? 1'b1 : // R14
    wr_flg ? sfr_wdata[efs_pkg::FLG_DONE] : done_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      space_r <= 1'b0; // R10
      permit_r <= 1'b0; // R12
      commit_r <= 1'b0;
      fetch_r <= 1'b0;
      done_r <= 1'b0;
      // abort survives reset; power-on clears it, a cut write sets it
      abort_r <= power_on ? 1'b0 : (busy ? 1'b1 : abort_r); // R13
    end
    else
    begin
      space_r <= space_nxt; // R10
      permit_r <= permit_nxt;
      commit_r <= commit_nxt;
      fetch_r <= fetch_nxt;
      abort_r <= abort_nxt;
      done_r <= done_nxt;
    end
  end

  chk_commit_permit: assert property ($rose(commit_r) |->
    $past(permit_r)) // R19
    else $error("commit set while permit was clear");

  chk_commit_sticky: assert property (
    (commit_r && !wr_done) |=> commit_r) // R11
    else $error("commit bit cleared before the write ended");

  chk_done_sets: assert property (wr_done |=> done_r && !commit_r
    && !abort_r) // R14
    else $error("done flag not set at write completion");

  chk_protect_block: assert property (
    (commit_req && space_nxt && prot_hit) |=> !commit_r) // R8
    else $error("write to protected program segment accepted");

  ////////////////////////////////////////////////////////////////////////
  // operation sequencer

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      op_r <= efs_pkg::EFS_OP_IDLE;
      cnt_r <= efs_pkg::CNT_ZERO;
      stall_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= efs_pkg::WORD_ZERO;
      wr_space_r <= 1'b0;
    end
    else
    begin
      case (op_r)
        efs_pkg::EFS_OP_IDLE:
        begin
          cnt_r <= efs_pkg::CNT_ZERO;
          if (commit_go)
          begin
            op_r <= efs_pkg::EFS_OP_WRITE;
            wr_space_r <= space_nxt;
            wr_addr_r <= space_nxt ? prog_addr : {5'h00, addr_low_r};
            wr_data_r <= {data_high_r, data_low_r}; // R2
          end
          else if (fetch_go && space_nxt)
            op_r <= efs_pkg::EFS_OP_PREAD;
        end
        efs_pkg::EFS_OP_PREAD:
        begin
          // first cycle runs normally, the second is taken by the array
          cnt_r <= cnt_r + CNT_ONE_W;
          stall_r <= !pm_load; // R21
          if (pm_load)
            op_r <= efs_pkg::EFS_OP_IDLE;
        end
        efs_pkg::EFS_OP_WRITE:
        begin
          cnt_r <= cnt_r + CNT_ONE_W; // R7
          if (wr_done)
            op_r <= efs_pkg::EFS_OP_IDLE;
        end
        default:
          op_r <= efs_pkg::EFS_OP_IDLE;
      endcase
    end
  end

  sequence s_pread_start;
    fetch_go && space_nxt;
  endsequence

  sequence s_pread_run;
    !cpu_stall ##1 cpu_stall ##1 (!cpu_stall && !fetch_r);
  endsequence

  chk_prog_read_stall: assert property (s_pread_start |=> s_pread_run)
    // R21
    else $error("program read stall not in the second cycle");

  ////////////////////////////////////////////////////////////////////////
  // behavioural arrays, no reset: contents are nonvolatile

  always_ff @(posedge sys_clk)
  begin
    if (wr_erase && !wr_space_r)
      ee_mem[wr_addr_r[7:0]] <= efs_pkg::ERASED_BYTE; // R6
    if (wr_done && !wr_space_r)
      ee_mem[wr_addr_r[7:0]] <= wr_data_r[7:0]; // R1 R6
    if (wr_erase && wr_space_r)
      pm_mem[prog_index(wr_addr_r)] <= efs_pkg::ERASED_WORD; // R23
    if (wr_done && wr_space_r)
      pm_mem[prog_index(wr_addr_r)] <= wr_data_r; // R23
  end

  ////////////////////////////////////////////////////////////////////////
  // register read mux, answered one cycle after the read strobe

  wire [7:0] ctl_rd = {space_r, 3'h0, abort_r, permit_r, commit_r,
    fetch_r};
  wire [7:0] flg_rd = {3'h0, done_r, 4'h0};
  wire [7:0] rd_mux =
    (sfr_sel == efs_pkg::IDX_DATA_LOW) ? data_low_r :
    (sfr_sel == efs_pkg::IDX_ADDR_LOW) ? addr_low_r :
    (sfr_sel == efs_pkg::IDX_DATA_HIGH) ? {2'h0, data_high_r} : // R16
    (sfr_sel == efs_pkg::IDX_ADDR_HIGH) ? {3'h0, addr_high_r} : // R17
    (sfr_sel == efs_pkg::IDX_CONTROL) ? ctl_rd :
    (sfr_sel == efs_pkg::IDX_FLAGS2) ? flg_rd :
    efs_pkg::BYTE_ZERO; // R15

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      sfr_rdata_r <= efs_pkg::BYTE_ZERO;
    else
      sfr_rdata_r <= sfr_rd ? rd_mux : efs_pkg::BYTE_ZERO;
  end

  chk_unlock_reads_zero: assert property (rd_key |=>
    sfr_rdata_r == efs_pkg::BYTE_ZERO) // R15
    else $error("unlock port read returned nonzero");

  chk_high_bits_zero: assert property (
    (sfr_rd && (sfr_sel == efs_pkg::IDX_DATA_HIGH ||
     sfr_sel == efs_pkg::IDX_ADDR_HIGH)) |=>
    sfr_rdata_r[7:6] == 2'h0) // R16 R17
    else $error("unimplemented high bits read nonzero");

  ////////////////////////////////////////////////////////////////////////
  // programmer read port; cpu access is never gated by code protection

  wire [13:0] pgm_word = pgm_space ? pm_mem[prog_index(pgm_addr)] :
    {6'h00, ee_mem[pgm_addr[7:0]]};

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pgm_rdata_r <= efs_pkg::WORD_ZERO;
      pgm_valid_r <= 1'b0;
      pgm_denied_r <= 1'b0;
    end
    else
    begin
      pgm_valid_r <= pgm_rd;
      pgm_denied_r <= pgm_rd && code_protect; // R9
      pgm_rdata_r <= (pgm_rd && !code_protect) ? pgm_word :
        efs_pkg::WORD_ZERO; // R9
    end
  end

  chk_code_protect: assert property ((pgm_rd && code_protect) |=>
    pgm_valid_r && pgm_denied_r && pgm_rdata_r == efs_pkg::WORD_ZERO)
    // R9
    else $error("programmer read not denied under code protection");

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata = sfr_rdata_r;
  assign cpu_stall = stall_r;
  assign nvm_done_flag = done_r;
  assign pgm_rdata = pgm_rdata_r;
  assign pgm_valid = pgm_valid_r;
  assign pgm_denied = pgm_denied_r;

endmodule : efs_core

`default_nettype wire

// ### efs_pgm_model.sv
/*
  efs_pgm_model: external programmer that reads the arrays through the
  programmer port of efs_core. Assumes the sys_clk domain, one read at
  a time, called as a task from the bench.
*/
`default_nettype none

module efs_pgm_model (
  // clock
  input wire logic sys_clk,
  // programmer port
  output logic pgm_rd,
  output logic pgm_space,
  output logic [12:0] pgm_addr,
  input wire logic [13:0] pgm_rdata,
  input wire logic pgm_valid,
  input wire logic pgm_denied
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    pgm_rd = 1'b0;
    pgm_space = 1'b0;
    pgm_addr = 13'h1555;
  end

  // idle lines show the inverse of the last request, never a stale copy
  task automatic fetch(input logic sp, input logic [12:0] a,
                       output logic [13:0] d, output logic v,
                       output logic den);
    @(posedge sys_clk);
    pgm_rd <= 1'b1;
    pgm_space <= sp;
    pgm_addr <= a;
    @(posedge sys_clk);
    pgm_rd <= 1'b0;
    pgm_space <= ~sp;
    pgm_addr <= ~a;
    #1;
    d = pgm_rdata;
    v = pgm_valid;
    den = pgm_denied;
  endtask : fetch

endmodule : efs_pgm_model

`default_nettype wire

// ### efs_core_test.sv
/*
  efs_core_test: self-checking bench of efs_core with a short write time.
  Assumes arrays start unknown, so every location read was written first.
*/
`default_nettype none

module efs_core_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WCYC = 8;
  logic sys_clk, rst_n, power_on, sfr_wr, sfr_rd, code_protect;
  logic [2:0] sfr_sel;
  logic [7:0] sfr_wdata, sfr_rdata;
  logic [1:0] self_program_protect;
  logic cpu_stall, nvm_done_flag, pgm_rd, pgm_space, pgm_valid, pgm_denied;
  logic [12:0] pgm_addr;
  logic [13:0] pgm_rdata;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  efs_core #(.PROG_AW(12), .WRITE_CYCLES(WCYC)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .power_on(power_on),
    .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .self_program_protect(self_program_protect),
    .code_protect(code_protect), .cpu_stall(cpu_stall),
    .nvm_done_flag(nvm_done_flag), .pgm_rd(pgm_rd), .pgm_space(pgm_space),
    .pgm_addr(pgm_addr), .pgm_rdata(pgm_rdata), .pgm_valid(pgm_valid),
    .pgm_denied(pgm_denied));

  efs_pgm_model i_pgm (
    .sys_clk(sys_clk), .pgm_rd(pgm_rd), .pgm_space(pgm_space),
    .pgm_addr(pgm_addr), .pgm_rdata(pgm_rdata), .pgm_valid(pgm_valid),
    .pgm_denied(pgm_denied));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string n, input logic [13:0] e,
                     input logic [13:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_sel <= s;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rchk(input string n, input logic [2:0] s,
                      input logic [7:0] e);
    @(posedge sys_clk);
    sfr_sel <= s;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1;
    chk(n, {6'h00, e}, {6'h00, sfr_rdata});
  endtask : rchk

  task automatic unlock_commit(input logic [7:0] ctl);
    wr(efs_pkg::IDX_UNLOCK, efs_pkg::UNLOCK_KEY1);
    wr(efs_pkg::IDX_UNLOCK, efs_pkg::UNLOCK_KEY2);
    wr(efs_pkg::IDX_CONTROL, ctl);
  endtask : unlock_commit

  // counts edges from the return of the commit write until done rises
  task automatic wait_done(output int n);
    n = 0;
    while (nvm_done_flag !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask : wait_done

  task automatic flag_clear();
    rchk("done flag", efs_pkg::IDX_FLAGS2, 8'h10);
    wr(efs_pkg::IDX_FLAGS2, 8'h00);
    rchk("done cleared", efs_pkg::IDX_FLAGS2, 8'h00);
  endtask : flag_clear

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset_map();
    logic [2:0] s;
    for (int i = 0; i < 8; i++)
    begin
      s = 3'(i);
      rchk("reset value", s, 8'h00);
    end
    wr(efs_pkg::IDX_DATA_HIGH, 8'hff);
    rchk("data high", efs_pkg::IDX_DATA_HIGH, 8'h3f);
    wr(efs_pkg::IDX_ADDR_HIGH, 8'hff);
    rchk("addr high", efs_pkg::IDX_ADDR_HIGH, 8'h1f);
    wr(3'h7, 8'h5a);
    rchk("unmapped", 3'h7, 8'h00);
    wr(efs_pkg::IDX_UNLOCK, 8'h33);
    rchk("unlock port", efs_pkg::IDX_UNLOCK, 8'h00);
    $display("test reset_map done");
  endtask : t_reset_map

  task automatic t_refused();
    unlock_commit(8'h02);
    rchk("commit no permit", efs_pkg::IDX_CONTROL, 8'h00);
    wr(efs_pkg::IDX_CONTROL, 8'h04);
    wr(efs_pkg::IDX_UNLOCK, efs_pkg::UNLOCK_KEY1);
    wr(efs_pkg::IDX_ADDR_LOW, 8'h40);
    wr(efs_pkg::IDX_UNLOCK, efs_pkg::UNLOCK_KEY2);
    wr(efs_pkg::IDX_CONTROL, 8'h06);
    rchk("broken sequence", efs_pkg::IDX_CONTROL, 8'h04);
    chk("no done", 14'h0, {13'h0, nvm_done_flag});
    wr(efs_pkg::IDX_CONTROL, 8'h00);
    rchk("zero write", efs_pkg::IDX_CONTROL, 8'h00);
    $display("test refused done");
  endtask : t_refused

  task automatic t_data(input logic [7:0] a, input logic [7:0] d);
    int n;
    wr(efs_pkg::IDX_ADDR_LOW, a);
    wr(efs_pkg::IDX_DATA_LOW, d);
    wr(efs_pkg::IDX_CONTROL, 8'h04);
    unlock_commit(8'h06);
    wait_done(n);
    chk("write time", 14'(WCYC), 14'(n));
    rchk("commit cleared", efs_pkg::IDX_CONTROL, 8'h04);
    flag_clear();
    wr(efs_pkg::IDX_DATA_LOW, ~d);
    wr(efs_pkg::IDX_CONTROL, 8'h01);
    rchk("data read", efs_pkg::IDX_DATA_LOW, d);
    $display("test data done");
  endtask : t_data

  task automatic t_prog();
    int n;
    self_program_protect <= efs_pkg::PROT_NONE;
    wr(efs_pkg::IDX_ADDR_HIGH, 8'h01);
    wr(efs_pkg::IDX_ADDR_LOW, 8'h23);
    wr(efs_pkg::IDX_DATA_LOW, 8'h5a);
    wr(efs_pkg::IDX_DATA_HIGH, 8'h2b);
    wr(efs_pkg::IDX_CONTROL, 8'h84);
    unlock_commit(8'h86);
    wait_done(n);
    chk("prog write time", 14'(WCYC), 14'(n));
    flag_clear();
    self_program_protect <= efs_pkg::PROT_LOW;
    wr(efs_pkg::IDX_ADDR_HIGH, 8'h00);
    wr(efs_pkg::IDX_ADDR_LOW, 8'h10);
    unlock_commit(8'h86);
    rchk("protected commit", efs_pkg::IDX_CONTROL, 8'h84);
    wr(efs_pkg::IDX_ADDR_HIGH, 8'h01);
    wr(efs_pkg::IDX_ADDR_LOW, 8'h23);
    wr(efs_pkg::IDX_DATA_LOW, 8'h00);
    wr(efs_pkg::IDX_DATA_HIGH, 8'h00);
    wr(efs_pkg::IDX_CONTROL, 8'h81);
    chk("no early stall", 14'h0, {13'h0, cpu_stall});
    @(posedge sys_clk);
    #1;
    chk("stall", 14'h1, {13'h0, cpu_stall});
    @(posedge sys_clk);
    #1;
    chk("stall end", 14'h0, {13'h0, cpu_stall});
    rchk("word low", efs_pkg::IDX_DATA_LOW, 8'h5a);
    rchk("word high", efs_pkg::IDX_DATA_HIGH, 8'h2b);
    $display("test prog done");
  endtask : t_prog

  task automatic t_programmer();
    logic [13:0] d;
    logic v, den;
    code_protect <= 1'b0;
    i_pgm.fetch(1'b1, 13'h0123, d, v, den);
    chk("pgm word", 14'h2b5a, d);
    chk("pgm valid", 14'h1, {13'h0, v});
    i_pgm.fetch(1'b0, 13'h00ff, d, v, den);
    chk("pgm byte", 14'h003c, d);
    code_protect <= 1'b1;
    i_pgm.fetch(1'b0, 13'h00ff, d, v, den);
    chk("pgm denied", 14'h1, {13'h0, den});
    chk("pgm denied data", 14'h0, d);
    code_protect <= 1'b0;
    $display("test programmer done");
  endtask : t_programmer

  task automatic t_abort();
    wr(efs_pkg::IDX_ADDR_LOW, 8'h80);
    wr(efs_pkg::IDX_CONTROL, 8'h04);
    unlock_commit(8'h06);
    @(posedge sys_clk);
    power_on <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk("abort flag", efs_pkg::IDX_CONTROL, 8'h08);
    chk("no done", 14'h0, {13'h0, nvm_done_flag});
    $display("test abort done");
  endtask : t_abort

  ////////////////////////////////////////////////////////////////////////
  // verdict, watchdog and main sequence
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    power_on = 1'b1;
    sfr_sel = 3'h0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    self_program_protect = efs_pkg::PROT_NONE;
    code_protect = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    power_on <= 1'b0;
    t_reset_map();
    t_refused();
    t_data(8'h00, 8'hc3);
    t_data(8'hff, 8'h3c);
    t_prog();
    t_programmer();
    t_abort();
    print_verdict();
  end

endmodule : efs_core_test

`default_nettype wire
